//--- verilog/adsc_consts.vh
// Constants for the dual converter serial control port
`ifndef ADSC_CONSTS_VH
`define ADSC_CONSTS_VH

// ----------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------
`define ADSC_WORD_W 12
`define ADSC_CMD_RESET 12'h000
`define ADSC_CMD_PAIR_HI 11
`define ADSC_CMD_PAIR_LO 10
`define ADSC_CMD_UPD_HI 9
`define ADSC_CMD_UPD_LO 8
`define ADSC_CMD_DEEP 7
`define ADSC_CMD_DOZE 6
`define ADSC_CMD_ADOZE 5
`define ADSC_CMD_REFOFF 4
`define ADSC_CMD_DUAL 3
`define ADSC_CMD_ACT_HI 2
`define ADSC_CMD_ACT_LO 0
`define ADSC_UPD_APPLY 2'h1
`define ADSC_ACT_DAC_WR 3'h1
`define ADSC_ACT_DAC_RD 3'h3
`define ADSC_ACT_RESET 3'h5

// ----------------------------------------------------------------
// Reference DAC register
// ----------------------------------------------------------------
`define ADSC_DAC_RESET 12'h3FF
`define ADSC_DAC_CODE_HI 9

// ----------------------------------------------------------------
// Input routing codes
// ----------------------------------------------------------------
`define ADSC_ROUTE_P0 2'h0
`define ADSC_ROUTE_P1 2'h3
`define ADSC_POS_P0_POS 2'h0
`define ADSC_POS_P1_NEG 2'h1
`define ADSC_POS_P1_POS 2'h2

// ----------------------------------------------------------------
// Sequencing and timing
// ----------------------------------------------------------------
`define ADSC_BITS_PER_WORD 4'hC
`define ADSC_CONV_CLOCKS 5'h10
`define ADSC_PAIR_LATCH_FALL 5'h02
`define ADSC_FRAME_W 32
`define ADSC_CLK_PERIOD_NS 8
`define ADSC_SOFT_RESET_NS 500
// Soft reset length: 500 ns at 8 ns per clock, rounded up, sized to the counter
`define ADSC_SOFT_RESET_CYCLES 7'h3F
`define ADSC_SOFT_CNT_W 7

`endif

//--- verilog/adsc_word_in.v
// Serial command word deserializer, one bit per sampled falling edge
`timescale 1ns/1ps
`include "adsc_consts.vh"

module adsc_word_in (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire start,
    input wire shift,
    input wire bit_in,
    output reg [`ADSC_WORD_W-1:0] word,
    output reg done
);

    reg [3:0] count;
    reg active;

    // ----------------------------------------------------------------
    // Shift path
    // ----------------------------------------------------------------
    // The strobe edge carries the first bit; twelve bits close the word
    always @(posedge clk) begin
        if (!rst_n) begin
            word <= `ADSC_CMD_RESET;
            count <= 4'h0;
            active <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                word <= {word[`ADSC_WORD_W-2:0], bit_in};
                count <= 4'h1;
                active <= 1'b1;
            end else if (shift && active) begin
                word <= {word[`ADSC_WORD_W-2:0], bit_in};
                count <= count + 4'h1;
                if (count + 4'h1 == `ADSC_BITS_PER_WORD) begin
                    active <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule

//--- verilog/adsc_frame_out.v
// Result frame serializer for one output line
`timescale 1ns/1ps
`include "adsc_consts.vh"

module adsc_frame_out (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire load,
    input wire shift,
    input wire [`ADSC_FRAME_W-1:0] frame,
    output reg bit_out
);

    reg [`ADSC_FRAME_W-1:0] shreg;

    // ----------------------------------------------------------------
    // Shift path
    // ----------------------------------------------------------------
    // Frame MSB appears at the strobe edge, so the third edge shows bit 29
    always @(posedge clk) begin
        if (!rst_n) begin
            shreg <= {`ADSC_FRAME_W{1'b0}};
            bit_out <= 1'b0;
        end else if (ce) begin
            if (load) begin
                shreg <= {frame[`ADSC_FRAME_W-2:0], 1'b0};
                bit_out <= frame[`ADSC_FRAME_W-1];
            end else if (shift) begin
                shreg <= {shreg[`ADSC_FRAME_W-2:0], 1'b0};
                bit_out <= shreg[`ADSC_FRAME_W-1];
            end
        end
    end

endmodule

//--- verilog/adsc_port.v
// Serial control, reference DAC and result framing of the dual converter
`timescale 1ns/1ps
`include "adsc_consts.vh"

// Overview of operation
// - Command bits shifted MSB first, reset zero
// - Command fields: pair, update, power, action
// - Pair select code routes converter inputs
// - Only update code 01 changes features
// - Action codes arm DAC write, read, reset
// - Power-down and reference-off bits take effect
// - Features apply at twelfth rising clock
// - DAC register twelve bits, reset 0x3FF
// - Result bits valid from third falling edge
// - Two's complement results, re-readable until next conversion ends
// - Mode pins choose selection and line use
// - Automatic mode alternates input pairs itself
// - Conversion lasts sixteen clocks, trigger holds
// - Busy high through whole conversion
// - Second falling edge latches next pair
// - Manual dual frame: 00, result, 00
// - Manual single: 0, converter, result, 00
// - Single line ignores trigger until B read
// - Automatic dual frame: pair, 0, result, 00
// - Automatic single frame; line B released once a conversion ends
// - Dual read returns both results per strobe
// - Armed write access loads ten DAC bits
// - Armed read sends 0000, DAC, 00
// - Reset action resets all, about 500 ns
module adsc_port (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire ser_clk,
    input wire rd_strobe,
    input wire sample_trigger,
    input wire cmd_serial_in,
    input wire out_enable_n,
    input wire auto_select_pin,
    input wire single_line_pin,
    input wire [11:0] conv_a_data,
    input wire [11:0] conv_b_data,
    output reg busy,
    output reg sample_hold,
    output wire result_line_a,
    output reg result_line_a_oe_n,
    output wire result_line_b,
    output reg result_line_b_oe_n,
    output reg [1:0] mux_pos_sel,
    output reg mux_neg_sel,
    output reg deep_sleep,
    output reg doze,
    output reg auto_doze,
    output reg ref_off,
    output reg [11:0] reference_dac_code
);

    // ----------------------------------------------------------------
    // Frame builder
    // ----------------------------------------------------------------
    function [`ADSC_FRAME_W-1:0] adsc_frame;
        input [1:0] lead;
        input [11:0] res;
        begin
            adsc_frame = {lead, res, 2'b00, 16'h0000};
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg sclk_q;
    reg trig_q;
    reg [`ADSC_SOFT_CNT_W-1:0] soft_cnt;
    reg [11:0] command_word;
    reg dual_read;
    reg apply_pending;
    reg arm_dac_wr;
    reg arm_dac_rd;
    reg acc_dac_wr;
    reg acc_dac_rd;
    reg [1:0] route;
    reg [1:0] conv_route;
    reg [4:0] conv_rise;
    reg [4:0] conv_fall;
    reg [11:0] res_a;
    reg [11:0] res_b;
    reg res_pair;
    reg next_is_b;
    reg b_pending;
    reg b_off;
    reg [`ADSC_FRAME_W-1:0] next_frame_a;
    reg [`ADSC_FRAME_W-1:0] next_frame_b;
    reg next_b_drive;
    wire sclk_fall;
    wire sclk_rise;
    wire trig_rise;
    wire rd_start;
    wire run_rst_n;
    wire [11:0] word_in;
    wire word_done;
    wire [1:0] mode;

    assign sclk_fall = sclk_q & ~ser_clk;
    assign sclk_rise = ~sclk_q & ser_clk;
    assign trig_rise = sample_trigger & ~trig_q;
    assign rd_start = sclk_fall & rd_strobe;
    assign mode = {auto_select_pin, single_line_pin};
    // Soft reset holds all but the edge detectors and its own timer in reset while it counts
    assign run_rst_n = rst_n & (soft_cnt == {`ADSC_SOFT_CNT_W{1'b0}});

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    adsc_word_in u_word_in (
        .clk(clk),
        .rst_n(run_rst_n),
        .ce(ce),
        .start(rd_start),
        .shift(sclk_fall),
        .bit_in(cmd_serial_in),
        .word(word_in),
        .done(word_done)
    );

    adsc_frame_out u_line_a (
        .clk(clk),
        .rst_n(run_rst_n),
        .ce(ce),
        .load(rd_start),
        .shift(sclk_fall),
        .frame(next_frame_a),
        .bit_out(result_line_a)
    );

    adsc_frame_out u_line_b (
        .clk(clk),
        .rst_n(run_rst_n),
        .ce(ce),
        .load(rd_start),
        .shift(sclk_fall),
        .frame(next_frame_b),
        .bit_out(result_line_b)
    );

    // ----------------------------------------------------------------
    // Edge detection and soft reset timer
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            trig_q <= 1'b0;
            soft_cnt <= {`ADSC_SOFT_CNT_W{1'b0}};
        end else if (ce) begin
            sclk_q <= ser_clk;
            trig_q <= sample_trigger;
            if (soft_cnt != {`ADSC_SOFT_CNT_W{1'b0}}) begin
                soft_cnt <= soft_cnt - {{(`ADSC_SOFT_CNT_W-1){1'b0}}, 1'b1};
            end else if (word_done && !acc_dac_wr && !acc_dac_rd &&
                         word_in[`ADSC_CMD_ACT_HI:`ADSC_CMD_ACT_LO] == `ADSC_ACT_RESET) begin
                soft_cnt <= `ADSC_SOFT_RESET_CYCLES;
            end
        end
    end

    // ----------------------------------------------------------------
    // Command and DAC registers
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!run_rst_n) begin
            command_word <= `ADSC_CMD_RESET;
            reference_dac_code <= `ADSC_DAC_RESET;
            deep_sleep <= 1'b0;
            doze <= 1'b0;
            auto_doze <= 1'b0;
            ref_off <= 1'b0;
            dual_read <= 1'b0;
            apply_pending <= 1'b0;
            arm_dac_wr <= 1'b0;
            arm_dac_rd <= 1'b0;
            acc_dac_wr <= 1'b0;
            acc_dac_rd <= 1'b0;
        end else if (ce) begin
            if (rd_start) begin
                acc_dac_wr <= arm_dac_wr;
                acc_dac_rd <= arm_dac_rd;
                arm_dac_wr <= 1'b0;
                arm_dac_rd <= 1'b0;
            end
            if (word_done) begin
                if (acc_dac_wr) begin
                    // Upper two bits are don't-care, only the code is kept
                    reference_dac_code <= {2'b00, word_in[`ADSC_DAC_CODE_HI:0]};
                    acc_dac_wr <= 1'b0;
                end else if (acc_dac_rd) begin
                    acc_dac_rd <= 1'b0;
                end else begin
                    command_word <= word_in;
                    apply_pending <= 1'b1;
                    arm_dac_wr <= (word_in[`ADSC_CMD_ACT_HI:`ADSC_CMD_ACT_LO] == `ADSC_ACT_DAC_WR);
                    arm_dac_rd <= (word_in[`ADSC_CMD_ACT_HI:`ADSC_CMD_ACT_LO] == `ADSC_ACT_DAC_RD);
                end
            end
            if (apply_pending && sclk_rise) begin
                apply_pending <= 1'b0;
                if (command_word[`ADSC_CMD_UPD_HI:`ADSC_CMD_UPD_LO] == `ADSC_UPD_APPLY) begin
                    deep_sleep <= command_word[`ADSC_CMD_DEEP];
                    doze <= command_word[`ADSC_CMD_DOZE];
                    auto_doze <= command_word[`ADSC_CMD_ADOZE];
                    ref_off <= command_word[`ADSC_CMD_REFOFF];
                    dual_read <= command_word[`ADSC_CMD_DUAL];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencing
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!run_rst_n) begin
            busy <= 1'b0;
            sample_hold <= 1'b0;
            route <= `ADSC_ROUTE_P0;
            conv_route <= `ADSC_ROUTE_P0;
            conv_rise <= 5'h00;
            conv_fall <= 5'h00;
            res_a <= 12'h000;
            res_b <= 12'h000;
            res_pair <= 1'b0;
            next_is_b <= 1'b0;
            b_pending <= 1'b0;
            b_off <= 1'b0;
            mux_pos_sel <= `ADSC_POS_P0_POS;
            mux_neg_sel <= 1'b0;
        end else if (ce) begin
            if (!single_line_pin) begin
                b_off <= 1'b0;
                b_pending <= 1'b0;
            end
            if (trig_rise && !busy && !b_pending && !deep_sleep && !doze) begin
                sample_hold <= 1'b1;
                busy <= 1'b1;
                conv_route <= route;
                conv_rise <= 5'h00;
                conv_fall <= 5'h00;
            end else if (busy && (deep_sleep || doze)) begin
                busy <= 1'b0;
                sample_hold <= 1'b0;
            end else if (busy) begin
                if (sclk_fall) begin
                    conv_fall <= conv_fall + 5'h01;
                    if (conv_fall + 5'h01 == `ADSC_PAIR_LATCH_FALL) begin
                        if (auto_select_pin) begin
                            route <= (route == `ADSC_ROUTE_P0) ? `ADSC_ROUTE_P1 : `ADSC_ROUTE_P0;
                        end else begin
                            route <= command_word[`ADSC_CMD_PAIR_HI:`ADSC_CMD_PAIR_LO];
                        end
                    end
                end
                if (sclk_rise) begin
                    conv_rise <= conv_rise + 5'h01;
                    if (conv_rise + 5'h01 == `ADSC_CONV_CLOCKS) begin
                        busy <= 1'b0;
                        sample_hold <= 1'b0;
                        // Held until the next conversion ends, so reads repeat
                        res_a <= conv_a_data;
                        res_b <= conv_b_data;
                        res_pair <= conv_route[1];
                        next_is_b <= 1'b0;
                        b_pending <= single_line_pin & ~dual_read;
                        b_off <= single_line_pin;
                    end
                end
            end
            if (rd_start && single_line_pin && !dual_read && !acc_dac_rd && !arm_dac_rd) begin
                next_is_b <= ~next_is_b;
                if (next_is_b) begin
                    b_pending <= 1'b0;
                end
            end
            case (route)
                2'h0: begin
                    mux_pos_sel <= `ADSC_POS_P0_POS;
                    mux_neg_sel <= 1'b0;
                end
                2'h1: begin
                    mux_pos_sel <= `ADSC_POS_P1_NEG;
                    mux_neg_sel <= 1'b0;
                end
                2'h2: begin
                    mux_pos_sel <= `ADSC_POS_P1_POS;
                    mux_neg_sel <= 1'b0;
                end
                default: begin
                    mux_pos_sel <= `ADSC_POS_P1_POS;
                    mux_neg_sel <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Frame selection per mode
    // ----------------------------------------------------------------
    always @* begin
        next_frame_a = adsc_frame(2'b00, res_a);
        next_frame_b = adsc_frame(2'b00, res_b);
        next_b_drive = 1'b1;
        case (mode)
            2'b00: begin
                next_frame_a = adsc_frame(2'b00, res_a);
                next_frame_b = adsc_frame(2'b00, res_b);
            end
            2'b10: begin
                next_frame_a = adsc_frame({res_pair, 1'b0}, res_a);
                next_frame_b = adsc_frame({res_pair, 1'b0}, res_b);
            end
            2'b01: begin
                if (dual_read) begin
                    next_frame_a = adsc_frame(2'b00, res_a);
                    next_frame_b = adsc_frame(2'b01, res_b);
                end else begin
                    next_b_drive = 1'b0;
                    next_frame_a = next_is_b ? adsc_frame(2'b01, res_b) : adsc_frame(2'b00, res_a);
                end
            end
            default: begin
                next_b_drive = ~b_off;
                if (dual_read) begin
                    next_frame_a = {adsc_frame({res_pair, 1'b0}, res_a) >> 16} |
                                   {adsc_frame({res_pair, 1'b1}, res_b) & 32'hFFFF0000};
                    next_frame_a = {next_frame_a[15:0], next_frame_a[31:16]};
                end else begin
                    next_frame_a = next_is_b ? adsc_frame({res_pair, 1'b1}, res_b) :
                                               adsc_frame({res_pair, 1'b0}, res_a);
                end
            end
        endcase
        if (arm_dac_rd) begin
            next_frame_a = {4'h0, reference_dac_code[`ADSC_DAC_CODE_HI:0], 2'b00, 16'h0000};
        end
    end

    // ----------------------------------------------------------------
    // Output enables
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!run_rst_n) begin
            result_line_a_oe_n <= 1'b1;
            result_line_b_oe_n <= 1'b1;
        end else if (ce) begin
            result_line_a_oe_n <= out_enable_n;
            result_line_b_oe_n <= out_enable_n | ~next_b_drive;
        end
    end

endmodule

//--- verif/adsc_port_checker.sv
// Concurrent checks on the ports of the serial control port
`timescale 1ns/1ps
module adsc_port_checker (
    input wire clk,
    input wire rst_n,
    input wire ser_clk,
    input wire sample_trigger,
    input wire out_enable_n,
    input wire busy,
    input wire sample_hold,
    input wire result_line_a_oe_n,
    input wire result_line_b_oe_n,
    input wire [1:0] mux_pos_sel,
    input wire mux_neg_sel,
    input wire deep_sleep,
    input wire doze,
    input wire auto_doze,
    input wire ref_off,
    input wire [11:0] reference_dac_code
);
reg ser_q;
reg [4:0] rise_cnt;
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
// Serial clock rises seen while a conversion runs
always @(posedge clk) begin
    ser_q <= ser_clk;
    if (!busy)
        rise_cnt <= 5'h00;
    else if (ser_clk && !ser_q)
        rise_cnt <= rise_cnt + 5'h01;
end
chk_dac_reset: assert property ($rose(rst_n) |-> reference_dac_code == 12'h3FF)
    else $error("DAC code wrong after reset");
chk_reset_state: assert property ($rose(rst_n) |-> !busy && !sample_hold && !deep_sleep && !doze)
    else $error("state wrong after reset");
chk_feat_reset: assert property ($rose(rst_n) |-> !auto_doze && !ref_off && result_line_a_oe_n)
    else $error("features or enable wrong after reset");
chk_busy_cause: assert property ($rose(busy) |-> $past(sample_trigger) && !$past(sample_trigger, 2))
    else $error("busy rose without a trigger rise");
chk_hold_start: assert property ($rose(busy) |-> sample_hold)
    else $error("no hold at conversion start");
chk_conv_length: assert property ($fell(busy) |-> !sample_hold && (rise_cnt == 5'h10 || deep_sleep || doze))
    else $error("conversion not sixteen clocks");
chk_outputs_off: assert property (out_enable_n |=> result_line_a_oe_n && result_line_b_oe_n)
    else $error("line driven while host disables");
chk_route_code: assert property (mux_pos_sel != 2'h3 && (!mux_neg_sel || mux_pos_sel == 2'h2))
    else $error("illegal input routing");
chk_route_when: assert property ($changed(mux_pos_sel) || $changed(mux_neg_sel) |-> busy)
    else $error("routing changed outside a conversion");
chk_dac_upper: assert property (reference_dac_code[11:10] != 2'h0 |-> reference_dac_code == 12'h3FF)
    else $error("DAC upper bits set");
endmodule

bind adsc_port adsc_port_checker chk (.clk, .rst_n, .ser_clk, .sample_trigger, .out_enable_n, .busy,
    .sample_hold, .result_line_a_oe_n, .result_line_b_oe_n, .mux_pos_sel, .mux_neg_sel, .deep_sleep,
    .doze, .auto_doze, .ref_off, .reference_dac_code);

//--- verif/adsc_host_model.sv
// Host side model: serial clock, strobe, command bits, trigger and result capture
`timescale 1ns/1ps
module adsc_host_model (
    input wire clk,
    input wire result_line_a,
    input wire result_line_b,
    output reg ser_clk,
    output reg rd_strobe,
    output reg cmd_serial_in,
    output reg sample_trigger
);
reg [15:0] cap_a;
reg [15:0] cap_b;
initial begin
    ser_clk = 1'h0;
    rd_strobe = 1'h0;
    cmd_serial_in = 1'h0;
    sample_trigger = 1'h0;
    cap_a = 16'h0000;
    cap_b = 16'h0000;
end
task wait_clk(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
endtask
// Serial clock idles low; the strobe goes with the first fall only
task access(input [11:0] word, input integer n, input trig);
    integer i;
    begin
        wait_clk(1);
        if (trig) begin
            sample_trigger = 1'h1;
            wait_clk(2);
            sample_trigger = 1'h0;
            wait_clk(2);
        end
        for (i = 0; i < n; i = i + 1) begin
            ser_clk = 1'h1;
            rd_strobe = 1'h0;
            wait_clk(3);
            ser_clk = 1'h0;
            rd_strobe = (i == 0);
            cmd_serial_in = (i < 12) ? word[11 - i] : i[0];
            wait_clk(3);
            cap_a = {cap_a[14:0], result_line_a};
            cap_b = {cap_b[14:0], result_line_b};
        end
    end
endtask
endmodule

//--- verif/adsc_port_bench.sv
// Self-checking bench for the dual converter serial control port
`timescale 1ns/1ps
module adsc_port_bench;
reg clk;
reg rst_n;
reg ce;
reg out_enable_n;
reg auto_select_pin;
reg single_line_pin;
reg [11:0] conv_a_data;
reg [11:0] conv_b_data;
wire ser_clk, rd_strobe, sample_trigger, cmd_serial_in, busy, sample_hold;
wire result_line_a, result_line_a_oe_n, result_line_b, result_line_b_oe_n;
wire [1:0] mux_pos_sel;
wire mux_neg_sel, deep_sleep, doze, auto_doze, ref_off;
wire [11:0] reference_dac_code;
integer err_count;
integer checked;
integer c;
adsc_port dut (.clk, .rst_n, .ce, .ser_clk, .rd_strobe, .sample_trigger, .cmd_serial_in, .out_enable_n,
    .auto_select_pin, .single_line_pin, .conv_a_data, .conv_b_data, .busy, .sample_hold, .result_line_a,
    .result_line_a_oe_n, .result_line_b, .result_line_b_oe_n, .mux_pos_sel, .mux_neg_sel, .deep_sleep,
    .doze, .auto_doze, .ref_off, .reference_dac_code);
adsc_host_model host (.clk, .result_line_a, .result_line_b, .ser_clk, .rd_strobe, .cmd_serial_in,
    .sample_trigger);
task check_val(input [15:0] got, input [15:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    end
endtask
task chk_feat(input [3:0] f);
    check_val({12'h000, deep_sleep, doze, auto_doze, ref_off}, {12'h000, f});
endtask
task acc(input [11:0] w, input trig);
    host.access(w, 16, trig);
endtask
task t_reset;
    begin
        check_val({4'h0, reference_dac_code}, 16'h03FF);
        chk_feat(4'h0);
    end
endtask
task t_features;
    begin
        acc(12'h1F0, 1'h0);
        chk_feat(4'hF);
        acc(12'h000, 1'h0);
        chk_feat(4'hF);
        acc(12'h300, 1'h0);
        chk_feat(4'hF);
        host.access(12'h100, 6, 1'h0);
        chk_feat(4'hF);
        acc(12'h100, 1'h0);
        chk_feat(4'h0);
    end
endtask
task t_mux;
    begin
        for (c = 3; c >= 0; c = c - 1) begin
            acc({c[1:0], 10'h000}, 1'h0);
            acc({c[1:0], 10'h000}, 1'h1);
            check_val({13'h0000, mux_neg_sel, mux_pos_sel}, {13'h0000, c == 3, (c == 3) ? 2'h2 : c[1:0]});
        end
    end
endtask
task t_mode1;
    begin
        out_enable_n = 1'h0;
        conv_a_data = 12'h7FF;
        conv_b_data = 12'h800;
        acc(12'h000, 1'h1);
        acc(12'h000, 1'h0);
        check_val(host.cap_a, {2'h0, 12'h7FF, 2'h0});
        check_val(host.cap_b, {2'h0, 12'h800, 2'h0});
        conv_a_data = 12'h000;
        conv_b_data = 12'hFFF;
        acc(12'h000, 1'h0);
        check_val(host.cap_a, {2'h0, 12'h7FF, 2'h0});
        acc(12'h000, 1'h1);
        acc(12'h000, 1'h0);
        check_val(host.cap_a, {2'h0, 12'h000, 2'h0});
        check_val(host.cap_b, {2'h0, 12'hFFF, 2'h0});
        check_val({15'h0000, result_line_a_oe_n}, 16'h0000);
    end
endtask
task t_dac;
    begin
        acc(12'h101, 1'h0);
        acc(12'h1A5, 1'h0);
        check_val({4'h0, reference_dac_code}, 16'h01A5);
        chk_feat(4'h0);
        acc(12'h103, 1'h0);
        acc(12'h1F0, 1'h0);
        check_val(host.cap_a, {4'h0, 10'h1A5, 2'h0});
        chk_feat(4'h0);
    end
endtask
task t_soft;
    begin
        acc(12'h105, 1'h0);
        host.wait_clk(70);
        check_val({4'h0, reference_dac_code}, 16'h03FF);
        acc(12'h110, 1'h0);
        chk_feat(4'h1);
    end
endtask
task t_mode2;
    begin
        single_line_pin = 1'h1;
        conv_a_data = 12'h123;
        conv_b_data = 12'h456;
        acc(12'h000, 1'h1);
        conv_a_data = 12'h7FF;
        conv_b_data = 12'h7FF;
        acc(12'h000, 1'h1);
        check_val(host.cap_a, {2'h0, 12'h123, 2'h0});
        acc(12'h000, 1'h0);
        check_val(host.cap_a, {2'h1, 12'h456, 2'h0});
        check_val({15'h0000, result_line_b_oe_n}, 16'h0001);
        conv_a_data = 12'h321;
        conv_b_data = 12'h654;
        acc(12'h108, 1'h1);
        acc(12'h108, 1'h0);
        check_val(host.cap_a, {2'h0, 12'h321, 2'h0});
        check_val(host.cap_b, {2'h1, 12'h654, 2'h0});
    end
endtask
task t_auto;
    begin
        single_line_pin = 1'h0;
        auto_select_pin = 1'h1;
        conv_a_data = 12'h111;
        conv_b_data = 12'h222;
        acc(12'h000, 1'h1);
        check_val({13'h0000, mux_neg_sel, mux_pos_sel}, 16'h0006);
        conv_a_data = 12'h333;
        conv_b_data = 12'h444;
        acc(12'h000, 1'h1);
        check_val(host.cap_a, {2'h0, 12'h111, 2'h0});
        check_val(host.cap_b, {2'h0, 12'h222, 2'h0});
        acc(12'h000, 1'h0);
        check_val(host.cap_a, {2'h2, 12'h333, 2'h0});
        check_val(host.cap_b, {2'h2, 12'h444, 2'h0});
        single_line_pin = 1'h1;
        acc(12'h000, 1'h1);
        host.access(12'h000, 32, 1'h0);
        check_val(host.cap_a, {2'h1, 12'h444, 2'h0});
        check_val({15'h0000, result_line_b_oe_n}, 16'h0001);
    end
endtask
task print_verdict;
    begin
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
endtask
initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
end
initial begin
    #160000;
    err_count = err_count + 1;
    print_verdict;
end
initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    out_enable_n = 1'h1;
    auto_select_pin = 1'h0;
    single_line_pin = 1'h0;
    conv_a_data = 12'h000;
    conv_b_data = 12'h000;
    err_count = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'h1;
    host.wait_clk(2);
    t_reset;
    t_features;
    t_mux;
    t_mode1;
    t_dac;
    t_soft;
    t_mode2;
    t_auto;
    print_verdict;
end
endmodule
